// ---- rtl/wiper_defines.svh ----
// Purpose : named constants of the dual wiper control logic
// Assumes : included by its bare name
// Notes   : opcodes sit in the top nibble of a 24-bit frame
`ifndef WIPER_DEFINES_SVH
`define WIPER_DEFINES_SVH

// =====================================================================
// frame layout
`define FRAME_BITS     5'h18
`define CNT_EMPTY      5'h00
`define FRAME_CLEAR    24'h000000
`define END_ON         2'h3

// =====================================================================
// opcodes
`define OP_NOP         4'h0
`define OP_RESTORE     4'h1
`define OP_STORE_WIPER 4'h2
`define OP_STORE_WORD  4'h3
`define OP_DEC6        4'h4
`define OP_DEC6_ALL    4'h5
`define OP_DEC1        4'h6
`define OP_DEC1_ALL    4'h7
`define OP_RESET       4'h8
`define OP_READ_WORD   4'h9
`define OP_READ_WIPER  4'hA
`define OP_WRITE_WIPER 4'hB
`define OP_INC6        4'hC
`define OP_INC6_ALL    4'hD
`define OP_INC1        4'hE
`define OP_INC1_ALL    4'hF

// =====================================================================
// store addresses and codes
`define ADDR_PRESET1   4'h0
`define ADDR_PRESET2   4'h1
`define ADDR_USER_LO   4'h2
`define ADDR_USER_HI   4'hE
`define ADDR_TOL       4'hF
`define CODE_ZERO      10'h000
`define CODE_ONE       10'h001
`define CODE_MID       10'h200
`define CODE_FULL      10'h3FF
`define WORD_BLANK     16'h0000
`define WORD_PAD       6'h00

`endif

// ---- rtl/wiper_pkg.sv ----
// Purpose : shared types of the dual wiper control logic
// Assumes : nothing
// Notes   : frame fields in transmit order, first bit at the top
package wiper_pkg;
   typedef logic [9:0]  code_t;
   typedef logic [15:0] word_t;
   typedef struct packed {
      logic [3:0] opcode;
      logic [3:0] addr;
      word_t      data;
   } frame_t;
endpackage

// ---- rtl/wiper_ctrl.sv ----
// Purpose : serial command decode, wiper codes, preset store, tap decode
// Assumes : serial pins synchronous to SYS_CLK, SCLK far slower
// Notes   : SDI taken on SCLK rising, SDO follows frame register top bit
//
// Behaviour
// - commands 12 and 13 double a wiper code one step
// - commands 4 and 5 halve a wiper code one step
// - ganged shift commands update both wipers in the same cycle
// - inside the range the increase shifts left inserting a zero
// - increase from zero loads code one
// - increase from midscale or above loads full scale and stays there
// - decrease shifts right inserting zero at top, stops at zero
// - bare chip select strobe repeats the previous command
// - store has sixteen 16-bit words: two presets, user words, tolerance
// - user words written by command 3 and read by command 9
// - tolerance word is factory set and host writes leave it unchanged
// - presets copied to wipers at power on, commands 1, 8, preset pin
// - tolerance word is sign, seven integer bits, eight fraction bits
// - wiper code picks one of 1024 taps, zero at the B end
// - exactly one tap switch on, end switch always on
// - a command runs only when chip select returns high
// - shift and step commands ignore the two data bytes
`timescale 1ns/10ps
`include "wiper_defines.svh"

module wiper_ctrl
   import wiper_pkg::*;
#(
   parameter int    TAPS    = 1024,
   parameter int    WORDS   = 16,
   // factory tolerance word, sign-magnitude; value is arbitrary
   parameter word_t TOL_VAL = 16'h8000
)(
   input  wire logic            SYS_CLK,
   input  wire logic            RST_N,
   input  wire logic            CS_N,
   input  wire logic            SCLK,
   input  wire logic            SDI,
   input  wire logic            PR_N,
   output logic                 SDO,
   output code_t                WIPER1_CODE,
   output code_t                WIPER2_CODE,
   output logic [TAPS-1:0]      TAP1_SWITCH,
   output logic [TAPS-1:0]      TAP2_SWITCH,
   output logic [1:0]           END_SWITCH
);

   // ==================================================================
   // helpers
   function automatic code_t shift_up(input code_t c);
      if (c == `CODE_ZERO)
         shift_up = `CODE_ONE;
      else if (c >= `CODE_MID)
         shift_up = `CODE_FULL;
      else
         shift_up = {c[8:0], 1'b0};
   endfunction

   function automatic code_t adjust(input logic [3:0] op, input code_t c);
      adjust = c;
      case (op)
         `OP_INC6, `OP_INC6_ALL: adjust = shift_up(c);
         `OP_DEC6, `OP_DEC6_ALL: adjust = {1'b0, c[9:1]};
         `OP_INC1, `OP_INC1_ALL:
            adjust = (c == `CODE_FULL) ? c : code_t'(c + `CODE_ONE);
         `OP_DEC1, `OP_DEC1_ALL:
            adjust = (c == `CODE_ZERO) ? c : code_t'(c - `CODE_ONE);
         default: adjust = c;
      endcase
   endfunction

   function automatic logic is_ganged(input logic [3:0] op);
      is_ganged = (op == `OP_INC6_ALL) || (op == `OP_DEC6_ALL) ||
                  (op == `OP_INC1_ALL) || (op == `OP_DEC1_ALL);
   endfunction

   function automatic logic is_single(input logic [3:0] op);
      is_single = (op == `OP_INC6) || (op == `OP_DEC6) ||
                  (op == `OP_INC1) || (op == `OP_DEC1);
   endfunction

   // ==================================================================
   // state
   logic                sclk_prev_q;
   logic                cs_prev_q;
   logic                pr_prev_q;
   logic [4:0]          cnt_q;
   logic [23:0]         sr_q;
   frame_t              last_q;
   logic                restore_q;
   code_t               w1_q;
   code_t               w2_q;
   code_t               w1_d;
   code_t               w2_d;
   // store contents survive reset; start blank
   word_t               store_q [WORDS] = '{default: `WORD_BLANK};
   logic [TAPS-1:0]     tap1_q;
   logic [TAPS-1:0]     tap2_q;
   logic                sdo_q;
   logic [1:0]          end_q;

   logic                sclk_rise;
   logic                cs_rise;
   logic                pr_fall;
   logic                exec;
   frame_t              cur;
   word_t               rd_word;

   // ==================================================================
   // edge detection and execute strobe
   assign sclk_rise = SCLK & ~sclk_prev_q;
   assign cs_rise   = CS_N & ~cs_prev_q;
   assign pr_fall   = ~PR_N & pr_prev_q;
   // an empty frame replays the last whole one
   assign cur  = (cnt_q == `CNT_EMPTY) ? last_q : frame_t'(sr_q);
   assign exec = cs_rise &&
                 (cnt_q == `CNT_EMPTY || cnt_q >= `FRAME_BITS);

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
         pr_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= SCLK;
         cs_prev_q   <= CS_N;
         pr_prev_q   <= PR_N;
      end
   end

   // ==================================================================
   // serial frame register
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         cnt_q <= `CNT_EMPTY;
      end else if (CS_N) begin
         cnt_q <= `CNT_EMPTY;
      end else if (sclk_rise && cnt_q <= `FRAME_BITS) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // tolerance word never lives in the writable array
   assign rd_word = (cur.addr == `ADDR_TOL) ? TOL_VAL
                                            : store_q[cur.addr];

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         sr_q <= `FRAME_CLEAR;
      end else if (!CS_N && sclk_rise) begin
         sr_q <= {sr_q[22:0], SDI};
      end else if (exec && cur.opcode == `OP_READ_WORD) begin
         sr_q[15:0] <= rd_word;
      end else if (exec && cur.opcode == `OP_READ_WIPER) begin
         sr_q[15:0] <= {`WORD_PAD, cur.addr[0] ? w2_q : w1_q};
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         last_q <= frame_t'(`FRAME_CLEAR);
      end else if (exec && cnt_q != `CNT_EMPTY) begin
         last_q <= frame_t'(sr_q);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         sdo_q <= 1'b0;
      end else begin
         sdo_q <= sr_q[23];
      end
   end

   // ==================================================================
   // nonvolatile store
   always_ff @(posedge SYS_CLK) begin
      if (exec && cur.opcode == `OP_STORE_WIPER) begin
         store_q[{3'h0, cur.addr[0]}] <=
            {`WORD_PAD, cur.addr[0] ? w2_q : w1_q};
      end else if (exec && cur.opcode == `OP_STORE_WORD &&
                   cur.addr != `ADDR_TOL) begin
         store_q[cur.addr] <= cur.data;
      end
   end

   // ==================================================================
   // wiper codes
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         restore_q <= 1'b1;
      end else begin
         restore_q <= 1'b0;
      end
   end

   // ganged forms touch both codes in one edge; data bytes read only by OP_WRITE_WIPER
   always_comb begin
      w1_d = w1_q;
      w2_d = w2_q;
      if (is_ganged(cur.opcode)) begin
         w1_d = adjust(cur.opcode, w1_q);
         w2_d = adjust(cur.opcode, w2_q);
      end else if (is_single(cur.opcode)) begin
         if (cur.addr[0])
            w2_d = adjust(cur.opcode, w2_q);
         else
            w1_d = adjust(cur.opcode, w1_q);
      end else if (cur.opcode == `OP_WRITE_WIPER) begin
         if (cur.addr[0])
            w2_d = cur.data[9:0];
         else
            w1_d = cur.data[9:0];
      end else if (cur.opcode == `OP_RESET) begin
         w1_d = store_q[`ADDR_PRESET1][9:0];
         w2_d = store_q[`ADDR_PRESET2][9:0];
      end else if (cur.opcode == `OP_RESTORE) begin
         if (cur.addr[0])
            w2_d = store_q[`ADDR_PRESET2][9:0];
         else
            w1_d = store_q[`ADDR_PRESET1][9:0];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         w1_q <= `CODE_ZERO;
         w2_q <= `CODE_ZERO;
      end else if (restore_q || pr_fall) begin
         w1_q <= store_q[`ADDR_PRESET1][9:0];
         w2_q <= store_q[`ADDR_PRESET2][9:0];
      end else if (exec) begin
         w1_q <= w1_d;
         w2_q <= w2_d;
      end
   end

   // ==================================================================
   // tap decode: one switch per string, end switch held on
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tap1_q <= {{(TAPS-1){1'b0}}, 1'b1};
         tap2_q <= {{(TAPS-1){1'b0}}, 1'b1};
         end_q  <= `END_ON;
      end else begin
         tap1_q <= {{(TAPS-1){1'b0}}, 1'b1} << w1_q;
         tap2_q <= {{(TAPS-1){1'b0}}, 1'b1} << w2_q;
         end_q  <= `END_ON;
      end
   end

   assign SDO         = sdo_q;
   assign WIPER1_CODE = w1_q;
   assign WIPER2_CODE = w2_q;
   assign TAP1_SWITCH = tap1_q;
   assign TAP2_SWITCH = tap2_q;
   assign END_SWITCH  = end_q;

   // ==================================================================
   // checks
   sequence s_inc6_w1;
      exec && cur.opcode == `OP_INC6 && !cur.addr[0];
   endsequence

   sequence s_empty_strobe;
      cs_rise && cnt_q == `CNT_EMPTY;
   endsequence

   a_inc_single: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      s_inc6_w1 and !restore_q && !pr_fall |=>
      w1_q == shift_up($past(w1_q)) && w2_q == $past(w2_q))
      else $error("single doubling step wrong");

   a_dec_ganged: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      exec && cur.opcode == `OP_DEC6_ALL && !restore_q && !pr_fall |=>
      w1_q == {1'b0, $past(w1_q[9:1])} &&
      w2_q == {1'b0, $past(w2_q[9:1])})
      else $error("ganged halving wrong");

   a_shl_zero: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      s_inc6_w1 and w1_q == `CODE_ZERO && !restore_q && !pr_fall |=>
      w1_q == `CODE_ONE)
      else $error("doubling from zero not one");

   a_shl_full: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      exec && cur.opcode == `OP_INC6_ALL && w2_q >= `CODE_MID &&
      !restore_q && !pr_fall |=> w2_q == `CODE_FULL)
      else $error("doubling at midscale not full");

   a_repeat_cmd: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      s_empty_strobe |-> exec && cur == last_q)
      else $error("empty strobe did not replay");

   a_cs_gate: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      !restore_q && !$past(restore_q) && $changed(w1_q) |->
      $past(exec) || $past(pr_fall))
      else $error("wiper moved without strobe");

   a_tol_fixed: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      exec && cur.opcode == `OP_READ_WORD && cur.addr == `ADDR_TOL |=>
      sr_q[15:0] == TOL_VAL)
      else $error("tolerance word altered");

   a_user_write: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      exec && cur.opcode == `OP_STORE_WORD && cur.addr >= `ADDR_USER_LO &&
      cur.addr <= `ADDR_USER_HI |=>
      store_q[$past(cur.addr)] == $past(cur.data))
      else $error("user word not stored");

   a_preset_pin: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      pr_fall |=> w1_q == store_q[`ADDR_PRESET1][9:0] &&
      w2_q == store_q[`ADDR_PRESET2][9:0])
      else $error("preset pin did not restore");

   a_tap_onehot: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      !restore_q |=> $onehot(tap1_q) && tap1_q[$past(w1_q)] &&
      end_q == `END_ON)
      else $error("tap decode wrong");

   // a frame cut short must not run nor become the replayed command
   sequence s_cut_frame;
      cs_rise && cnt_q != `CNT_EMPTY && cnt_q < `FRAME_BITS;
   endsequence

   a_cut_frame: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      s_cut_frame and !restore_q && !pr_fall |=>
      $stable(w1_q) && $stable(w2_q) && $stable(last_q))
      else $error("short frame was executed");

   a_ganged_inc: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      exec && cur.opcode == `OP_INC6_ALL && !restore_q && !pr_fall |=>
      w1_q == shift_up($past(w1_q)) &&
      w2_q == shift_up($past(w2_q)))
      else $error("ganged doubling not joint");

   a_dec_floor: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      exec && cur.opcode == `OP_DEC6 && cur.addr[0] &&
      w2_q == `CODE_ZERO && !restore_q && !pr_fall |=>
      w2_q == `CODE_ZERO && $stable(w1_q))
      else $error("halving went below zero");

   // first edge out of reset carries the power-on preset load
   a_power_restore: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      restore_q && RST_N |=>
      w1_q == $past(store_q[`ADDR_PRESET1][9:0]) &&
      w2_q == $past(store_q[`ADDR_PRESET2][9:0]))
      else $error("presets not loaded after reset");

endmodule

// ---- dv/wiper_host.sv ----
// Purpose : host model driving serial command frames into the wiper logic
// Assumes : SCLK high and low for two SYS_CLK cycles each
// Notes   : SDO captured before each shift, so bit 23 comes first
`timescale 1ns/10ps

module wiper_host
   import wiper_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic sdo,
   output logic      cs_n,
   output logic      sclk,
   output logic      sdi,
   output logic      pr_n
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi  = 1'b0;
      pr_n = 1'b1;
   end

   // =====================================================================
   // frame transfer; 1 to 23 bits makes a frame the device drops, 0 bits replays the last frame
   task automatic send(input frame_t f, input int nbits, output frame_t rd);
      rd = '0;
      @(posedge sys_clk) cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         @(posedge sys_clk) sdi <= f[23-i];
         @(posedge sys_clk);
         rd = {rd[22:0], sdo};
         sclk <= 1'b1;
         repeat (2) @(posedge sys_clk);
         sclk <= 1'b0;
      end
      @(posedge sys_clk) cs_n <= 1'b1;
      // idle data line is not held, so flip it to expose stale sampling
      sdi <= ~sdi;
   endtask

   // bare select pulse with no clock edges
   task automatic strobe();
      @(posedge sys_clk) cs_n <= 1'b0;
      @(posedge sys_clk) cs_n <= 1'b1;
   endtask

   task automatic preset();
      @(posedge sys_clk) pr_n <= 1'b0;
      @(posedge sys_clk) pr_n <= 1'b1;
   endtask
endmodule

// ---- dv/tb.sv ----
// Purpose : self-checking bench of the dual wiper control logic
// Assumes : nonvolatile store starts all zero except the tolerance word
// Notes   : integer model of wipers and store; wipers and taps compared after every frame, store only on reads
`timescale 1ns/10ps
`include "wiper_defines.svh"

module tb;
   import wiper_pkg::*;
   // factory tolerance word; value is arbitrary
   localparam word_t TOL = 16'h8A40;
   logic          sys_clk;
   logic          rst_n;
   logic          cs_n;
   logic          sclk;
   logic          sdi;
   logic          pr_n;
   logic          sdo;
   code_t         w1;
   code_t         w2;
   logic [1023:0] t1;
   logic [1023:0] t2;
   logic [1:0]    ends;
   int            num_errors = 0;
   int            total_checks = 0;
   int            wip[2];
   int            mem[16];
   frame_t        rd;

   wiper_ctrl #(.TOL_VAL(TOL)) i_wiper_ctrl (
      .SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk),
      .SDI(sdi), .PR_N(pr_n), .SDO(sdo), .WIPER1_CODE(w1),
      .WIPER2_CODE(w2), .TAP1_SWITCH(t1), .TAP2_SWITCH(t2),
      .END_SWITCH(ends));

   wiper_host i_wiper_host (.sys_clk(sys_clk), .sdo(sdo), .cs_n(cs_n),
      .sclk(sclk), .sdi(sdi), .pr_n(pr_n));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // =====================================================================
   // checking and model
   task automatic check(input string what, input logic [1023:0] seen,
                        input logic [1023:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   function automatic int up(input int c);
      if (c == 0) return 1;
      if (c >= 10'h200) return 10'h3FF;
      return c * 2;
   endfunction

   task automatic restore();
      wip[0] = mem[0] % 1024;
      wip[1] = mem[1] % 1024;
   endtask

   task automatic model(input frame_t f);
      int a;
      a = f.addr[0];
      case (f.opcode)
         `OP_INC6:       wip[a] = up(wip[a]);
         `OP_INC6_ALL:   wip = '{up(wip[0]), up(wip[1])};
         `OP_DEC6:       wip[a] = wip[a] / 2;
         `OP_DEC6_ALL:   wip = '{wip[0] / 2, wip[1] / 2};
         `OP_WRITE_WIPER: wip[a] = f.data[9:0];
         `OP_STORE_WORD: if (f.addr != 4'hF) mem[f.addr] = f.data;
         `OP_RESTORE:    wip[a] = mem[a] % 1024;
         `OP_STORE_WIPER: mem[a] = wip[a];
         `OP_INC1:       wip[a] = (wip[a] < 1023) ? wip[a] + 1 : 1023;
         `OP_DEC1:       wip[a] = (wip[a] > 0) ? wip[a] - 1 : 0;
         `OP_INC1_ALL:   foreach (wip[i])
                            wip[i] = (wip[i] < 1023) ? wip[i] + 1 : 1023;
         `OP_DEC1_ALL:   foreach (wip[i])
                            wip[i] = (wip[i] > 0) ? wip[i] - 1 : 0;
         `OP_RESET:      restore();
         default: ;
      endcase
   endtask

   task automatic settle();
      logic [1023:0] e1;
      logic [1023:0] e2;
      repeat (2) @(posedge sys_clk);
      #1;
      check("wiper1", w1, wip[0]);
      check("wiper2", w2, wip[1]);
      @(posedge sys_clk);
      #1;
      e1 = '0;
      e2 = '0;
      e1[wip[0]] = 1'b1;
      e2[wip[1]] = 1'b1;
      check("tap1", t1, e1);
      check("tap2", t2, e2);
      check("ends", ends, 2'h3);
   endtask

   task automatic cmd(input logic [3:0] op, input logic [3:0] ad,
                      input word_t d);
      i_wiper_host.send({op, ad, d}, 24, rd);
      model({op, ad, d});
      settle();
   endtask

   // =====================================================================
   // main sequence
   initial begin
      frame_t last;
      rst_n = 1'b0;
      void'($urandom(91));
      wip = '{0, 0};
      foreach (mem[i]) mem[i] = 0;
      mem[15] = TOL;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      settle();
      for (int a = 2; a < 16; a++)
         cmd(`OP_STORE_WORD, a[3:0], word_t'($urandom));
      for (int a = 0; a < 16; a++) begin
         cmd(`OP_READ_WORD, a[3:0], word_t'($urandom));
         cmd(`OP_NOP, 4'h0, word_t'($urandom));
         check("word", rd[15:0], word_t'(mem[a]));
      end
      check("tolerance", rd[15:0], TOL);
      cmd(`OP_WRITE_WIPER, 4'h0, 16'h0000);
      for (int i = 0; i < 12; i++)
         cmd(`OP_INC6, 4'h0, word_t'($urandom));
      cmd(`OP_WRITE_WIPER, 4'h1, 16'h03FF);
      for (int i = 0; i < 11; i++)
         cmd(`OP_DEC6, 4'h1, word_t'($urandom));
      cmd(`OP_WRITE_WIPER, 4'h0, 16'h0003);
      cmd(`OP_WRITE_WIPER, 4'h1, {6'h00, 10'($urandom)});
      for (int i = 0; i < 6; i++)
         cmd(i < 3 ? `OP_INC6_ALL : `OP_DEC6_ALL, 4'($urandom),
             word_t'($urandom));
      cmd(`OP_WRITE_WIPER, 4'h0, 16'h03FE);
      cmd(`OP_WRITE_WIPER, 4'h1, 16'h0001);
      for (int i = 0; i < 3; i++) begin
         cmd(`OP_INC1, 4'h0, word_t'($urandom));
         cmd(`OP_DEC1, 4'h1, word_t'($urandom));
      end
      cmd(`OP_DEC1_ALL, 4'($urandom), word_t'($urandom));
      cmd(`OP_INC1_ALL, 4'($urandom), word_t'($urandom));
      cmd(`OP_STORE_WIPER, 4'h0, word_t'($urandom));
      cmd(`OP_READ_WIPER, 4'h1, word_t'($urandom));
      cmd(`OP_READ_WORD, 4'h0, word_t'($urandom));
      check("wiper read", rd[15:0], word_t'(wip[1]));
      cmd(`OP_NOP, 4'h0, word_t'($urandom));
      check("preset word", rd[15:0], word_t'(mem[0]));
      last = {`OP_INC6, 4'h1, 16'h0000};
      cmd(last.opcode, last.addr, last.data);
      for (int i = 0; i < 2; i++) begin
         i_wiper_host.strobe();
         model(last);
         settle();
      end
      i_wiper_host.send({`OP_INC6_ALL, 8'h00, 16'h0000}, 12, rd);
      settle();
      i_wiper_host.strobe();
      model(last);
      settle();
      cmd(`OP_STORE_WORD, 4'h0, word_t'($urandom));
      cmd(`OP_STORE_WORD, 4'h1, word_t'($urandom));
      cmd(`OP_WRITE_WIPER, 4'h1, 16'h0155);
      cmd(`OP_RESTORE, 4'h1, 16'h0000);
      cmd(`OP_WRITE_WIPER, 4'h0, 16'h02AA);
      cmd(`OP_RESET, 4'h0, 16'h0000);
      cmd(`OP_WRITE_WIPER, 4'h0, 16'h0011);
      i_wiper_host.preset();
      restore();
      settle();
      cmd(`OP_WRITE_WIPER, 4'h1, 16'h0022);
      @(posedge sys_clk) rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      check("reset wiper", w2, 10'h000);
      restore();
      settle();
      results();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      num_errors++;
      results();
   end
endmodule
